// [bench/esx_dcache_model.sv]
// data cache store port model: hit, or miss with a reload some cycles later
// assumes the block's combinational store request on the same mclk
`timescale 1ns/100ps
module esx_dcache_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// store request from the block
	input  wire logic       req,
	input  wire logic [1:0] idx,
	input  wire logic [11:0] ea,
	// answers
	output logic            hit,
	output logic            miss,
	output logic            fill,
	output logic [1:0]      fill_idx
);
	logic [2:0] wait_reg;
	// odd addresses miss so the reload path gets exercised
	assign hit  = req & ~ea[0];
	assign miss = req & ea[0];
	// reload timer; idle index toggles so a stale value is never trusted
	always_ff @(posedge mclk) begin
		fill <= (wait_reg == 3'h1);
		if (rst) begin
			wait_reg <= 3'h0;
			fill_idx <= 2'h0;
		end else if (miss) begin
			wait_reg <= 3'h4;
			fill_idx <= idx;
		end else begin
			wait_reg <= (wait_reg != 3'h0) ? wait_reg - 3'h1 : 3'h0;
			if (wait_reg == 3'h0)
				fill_idx <= ~fill_idx;
		end
	end
endmodule

// [bench/tb_top.sv]
// testbench for the execution control block, scoreboard of unit results
// assumes esx_pkg compiled first and the cache model beside it
`timescale 1ns/100ps
module tb_top;
	import esx_pkg::*;
	logic mclk, rst, cr_ok, flush, st_hold, st_word, req, hit, miss, fill, oldv, hitf;
	logic [5:0] rdy;
	logic [5:0][1:0] op_rdy;
	logic [3:0] oldt, rtag;
	logic [1:0] widx, fidx;
	logic [11:0] wea, ea;
	logic [31:0] tgt, got;
	esx_disp_type disp, lsd;
	esx_cmpl_type cmpl;
	esx_br_type br;
	esx_redir_type redir;
	esx_iss_type [5:0] iss;
	esx_iss_type mcd, fpd;
	logic fwd;
	int failures, compares, cyc, seed, i;
	logic [19:0] notes[$];
	esx_exec_ctl uut (.mclk(mclk), .rst(rst), .disp_i(disp), .disp_rdy_o(rdy),
		.cr_read_ok_o(cr_ok), .op_rdy_i(op_rdy), .oldest_v_i(oldv), .oldest_tag_i(oldt),
		.cmpl_i(cmpl), .flush_o(flush), .refetch_tag_o(rtag), .br_res_i(br), .redir_o(redir),
		.iss_o(iss), .mc_done_o(mcd), .fp_done_o(fpd), .fp_cr_fwd_o(fwd), .ls_done_o(lsd),
		.str_hold_o(st_hold), .str_word_o(st_word), .dc_wr_req_o(req), .dc_wr_idx_o(widx),
		.dc_wr_ea_o(wea), .dc_hit_i(hit), .dc_miss_i(miss), .dc_fill_i(fill),
		.dc_fill_idx_i(fidx));
	esx_dcache_model cache (.mclk(mclk), .rst(rst), .req(req), .idx(widx), .ea(wea),
		.hit(hit), .miss(miss), .fill(fill), .fill_idx(fidx));
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one dispatch; the expected result cycle is noted when lat is nonzero
	task send(input logic [2:0] u, input esx_cls_type c, input logic [3:0] tg, input int lat);
		@(posedge mclk);
		disp <= '{valid:1'b1, unit:u, cls:c, tag:tg, ea_lo:ea, uncached:1'b0,
			short_op:1'b1, oe:1'b0, words:5'h01};
		@(negedge mclk);
		if (lat > 0)
			notes.push_back({tg, 16'(cyc + lat)});
	endtask
	// one unit result takes the oldest note
	task take(input logic [3:0] tg);
		if (notes.size() == 0)
			chk("stray_result", 1, 0);
		else
			chk("result_time", {tg, cyc[15:0]}, notes.pop_front());
	endtask
	task idle;
		@(posedge mclk);
		disp <= '0;
	endtask
	// poll a flag at settled points for a bounded number of cycles
	task poll(input int n, input int which);
		hitf = 1'b0;
		repeat (n) begin
			@(negedge mclk);
			if ((which == 0 && iss[0].valid === 1'b1) || (which == 1 && redir.valid === 1'b1)
				|| (which == 2 && req === 1'b1)) begin
				hitf = 1'b1;
				got = (which == 1) ? redir.addr : {20'h0, wea};
			end
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// cycle count and hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			failures = failures + 1;
			tally_and_finish();
		end
	end
	// scoreboard: each unit result takes the oldest note
	always @(negedge mclk) begin
		// results of one cycle are taken in float, multicycle, load/store order
		if (!rst) begin
			if (fpd.valid === 1'b1)
				take(fpd.tag);
			if (mcd.valid === 1'b1)
				take(mcd.tag);
			if (lsd.valid === 1'b1)
				take(lsd.tag);
		end
	end
	initial begin
		seed = 77;
		failures = 0;
		compares = 0;
		cyc = 0;
		rst = 1'b1;
		disp = '0;
		cmpl = '0;
		br = '0;
		op_rdy = '1;
		oldv = 1'b1;
		oldt = 4'h0;
		ea = 12'h000;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("rdy_reset", rdy, 6'h3F);
		// back-to-back float, short multiply, load
		send(4, CLS_FARITH, 1, 4);
		send(4, CLS_FARITH, 2, 4);
		send(3, CLS_MUL, 3, 4);
		send(5, CLS_LOAD, 4, 3);
		idle();
		repeat (8) @(posedge mclk);
		$display("test pipes done");
		// long multicycle and blocking float latencies, then a string op
		send(3, CLS_MTCTLR, 4'hC, 3);
		idle();
		repeat (4) @(posedge mclk);
		send(3, CLS_DIV, 4'hD, 22);
		idle();
		repeat (24) @(posedge mclk);
		send(4, CLS_FDIV, 4'hE, 34);
		idle();
		repeat (36) @(posedge mclk);
		send(5, CLS_STRING, 4'hF, 3);
		idle();
		@(negedge mclk);
		chk("str_hold", {st_hold, rdy}, 7'h40);
		repeat (4) @(posedge mclk);
		$display("test long ops done");
		// serialized op waits for oldest while a later float runs on
		send(0, CLS_CRLOG, 5, 0);
		send(4, CLS_FARITH, 6, 4);
		idle();
		poll(6, 0);
		chk("serial_early", hitf, 0);
		oldt <= 4'h5;
		poll(4, 0);
		chk("serial_go", hitf, 1);
		$display("test serial done");
		// full station, then every flush cause and one non-cause
		op_rdy[1] <= 2'b00;
		send(1, CLS_ADD, 7, 0);
		send(1, CLS_ADD, 8, 0);
		idle();
		@(negedge mclk);
		chk("station_full", rdy[1], 0);
		op_rdy[1] <= 2'b11;
		for (i = 0; i < 11; i++) begin
			@(posedge mclk);
			cmpl <= '{valid:1'b1, tag:4'(i), cls:(i == 0) ? CLS_MTXER : (i == 1) ? CLS_MCRXR :
				(i == 2) ? CLS_ISYNC : (i == 7) ? CLS_ADD : (i == 8) ? CLS_STRING :
				(i == 9) ? CLS_FSTAT : (i == 10) ? CLS_MCRFS : CLS_FARITH, sets_so:(i == 3),
				trap_ve:(i == 4), trap_ze:(i == 5), record:(i == 6), str_zero:(i == 8)};
			@(posedge mclk);
			cmpl <= '0;
			@(negedge mclk);
			chk("flush", flush, i != 7);
			if (i != 7)
				chk("refetch_tag", rtag, i);
			@(negedge mclk);
			chk("flush_frees", rdy, 6'h3F);
		end
		$display("test flush done");
		// mispredicted direction redirects to the actual target
		tgt = $random(seed);
		br <= '{pred_taken:1'b0, pred_target:tgt, taken:1'b1, target:tgt};
		send(0, CLS_BRANCH, 10, 0);
		idle();
		poll(6, 1);
		chk("redirect", got, tgt);
		$display("test branch done");
		// two stores: first misses and reloads, second hits
		for (i = 0; i < 2; i++) begin
			ea = 12'($random(seed)) & 12'hFFE | 12'(i == 0);
			send(5, CLS_STORE, 4'(11 + i), 3);
			idle();
			repeat (3) @(posedge mclk);
			cmpl <= '{valid:1'b1, tag:4'(11 + i), cls:CLS_STORE, default:1'b0};
			@(posedge mclk);
			cmpl <= '0;
			poll(1, 2);
			if (hitf !== 1'b1)
				poll(8, 2);
			chk("store_ea", got, {20'h0, ea});
			repeat (8) @(posedge mclk);
		end
		$display("test stores done");
		chk("notes_left", notes.size(), 0);
		tally_and_finish();
	end
endmodule

// [hdl/esx_consts.svh]
// constants for the execution-side serialization and unit timing block
// assumes inclusion by esx_pkg and by the block itself
`ifndef ESX_CONSTS_SVH
`define ESX_CONSTS_SVH
`define ESX_UNITS       6
`define ESX_U_BR        0
`define ESX_U_SI0       1
`define ESX_U_SI1       2
`define ESX_U_MC        3
`define ESX_U_FP        4
`define ESX_U_LS        5
`define ESX_RS_FULL     2'b11
`define ESX_BR_MAX      2'd2
`define ESX_SQ_DEPTH    4
`define ESX_ALIAS_BITS  12
`define ESX_FP_BLK_STAT 6'd2
`define ESX_FDIV_CYC    6'd33
`define ESX_FDIVS_CYC   6'd18
`define ESX_FRES_CYC    6'd18
`define ESX_MUL_SHORT   6'd2
`define ESX_MUL_LONG    6'd4
`define ESX_DIV_CYC     6'd20
`define ESX_SPR_CYC     6'd1
`endif

// [hdl/esx_exec_ctl.sv]
// execution-side control: reservation stations, serialization, unit timing
// assumes dispatcher, completion unit and data cache on the same mclk
`timescale 1ns/100ps
`include "esx_consts.svh"

// How it works
// - serialized op issues only when oldest, waiting
// - serialized op blocks later ones only in branch, float, load/store stations
// - cr logic, spr/msr moves, carry ops serialize
// - post-serialized completion flushes all younger work
// - xer, isync, so, string0, float cases flush
// - string ops split, one word per cycle
// - string holds dispatch buffer one cycle minimum
// - uncached loads stay ordered around barrier
// - two unresolved plus two resolved branches max
// - branch mismatch redirects fetch to actual target
// - only branch and cr logic read cr
// - simple unit has adder, logic, shifter subunits
// - multicycle unit multiplies, early exit, spr moves
// - multicycle ops complete on finish, with exceptions
// - float pipe three deep, three cycle latency
// - divides and status moves block float pipe
// - float cr result forwarded except status move
// - float issues in order, result broadcast
// - load/store two stages, two cycle latency
// - load waits on older store low-12 alias
// - store queue finished, completed, committed regions
// - commit on hit, miss waits, next may go
// - two-entry stations, dispatch refused when full
module esx_exec_ctl (
	// clock and reset
	input  logic                          mclk,
	input  logic                          rst,
	// dispatch
	input  esx_pkg::esx_disp_type         disp_i,
	output logic [5:0]                    disp_rdy_o,
	output logic                          cr_read_ok_o,
	input  logic [5:0][1:0]               op_rdy_i,
	// completion
	input  logic                          oldest_v_i,
	input  logic [3:0]                    oldest_tag_i,
	input  esx_pkg::esx_cmpl_type         cmpl_i,
	output logic                          flush_o,
	output logic [3:0]                    refetch_tag_o,
	// branch
	input  esx_pkg::esx_br_type           br_res_i,
	output esx_pkg::esx_redir_type        redir_o,
	// issue and unit results
	output esx_pkg::esx_iss_type [5:0]    iss_o,
	output esx_pkg::esx_iss_type          mc_done_o,
	output esx_pkg::esx_iss_type          fp_done_o,
	output logic                          fp_cr_fwd_o,
	output esx_pkg::esx_disp_type         ls_done_o,
	// string sequencer
	output logic                          str_hold_o,
	output logic                          str_word_o,
	// data cache store port
	output logic                          dc_wr_req_o,
	output logic [1:0]                    dc_wr_idx_o,
	output logic [11:0]                   dc_wr_ea_o,
	input  logic                          dc_hit_i,
	input  logic                          dc_miss_i,
	input  logic                          dc_fill_i,
	input  logic [1:0]                    dc_fill_idx_i
);
	import esx_pkg::*;

	function automatic logic exec_ser(esx_cls_type c);
		return c inside {CLS_CRLOG, CLS_MFSPR, CLS_MTSPR, CLS_CARRY};
	endfunction

	function automatic logic is_fp(esx_cls_type c);
		return c inside {CLS_FARITH, CLS_FDIV, CLS_FDIVS, CLS_FRES};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// post-dispatch serialization decided at completion
	logic         flush_now;
	logic         flush_reg;
	logic [3:0]   refetch_reg;

	assign flush_now = cmpl_i.valid &&
		(cmpl_i.cls inside {CLS_MTXER, CLS_MCRXR, CLS_ISYNC, CLS_FSTAT, CLS_MCRFS} ||
		cmpl_i.sets_so || cmpl_i.str_zero || cmpl_i.trap_ve || cmpl_i.trap_ze ||
		(cmpl_i.record && is_fp(cmpl_i.cls)));

	// refetch starts after the serializing instruction itself
	always_ff @(posedge mclk) begin
		flush_reg   <= rst ? 1'b0 : flush_now;
		refetch_reg <= rst ? 4'h0 : cmpl_i.tag;
	end
	assign flush_o       = flush_reg;
	assign refetch_tag_o = refetch_reg;

	////////////////////////////////////////////////////////////////////////
	// serialized ops see the oldest tag held two cycles, so they wait
	logic         old_v_reg;
	logic [3:0]   old_tag_reg;
	always_ff @(posedge mclk) begin
		old_v_reg   <= rst ? 1'b0 : oldest_v_i;
		old_tag_reg <= rst ? 4'h0 : oldest_tag_i;
	end

	////////////////////////////////////////////////////////////////////////
	// reservation stations, one generate entry per unit
	esx_disp_type rs_reg [`ESX_UNITS][2];
	logic [1:0]   rs_v_reg [`ESX_UNITS];
	logic [5:0]   go;
	logic [5:0]   sel;
	logic [5:0]   unit_free;
	esx_iss_type  iss_reg [`ESX_UNITS];
	esx_str_type  str_reg;

	assign cr_read_ok_o = disp_i.valid && disp_i.cls inside {CLS_BRANCH, CLS_CRLOG};

	genvar u;
	generate
		for (u = 0; u < `ESX_UNITS; u++) begin : g_rs
			logic         el0;
			logic         el1;
			logic         dacc;
			logic [1:0]   v_next;
			esx_disp_type e0_next;
			esx_disp_type e1_next;
			logic [2:0]   sub;

			// in simple and multicycle stations a held serialized entry leaves the other slot free to go
			assign el0 = rs_v_reg[u][0] && op_rdy_i[u][0] && (!exec_ser(rs_reg[u][0].cls) ||
				(old_v_reg && oldest_v_i && old_tag_reg == rs_reg[u][0].tag &&
				oldest_tag_i == rs_reg[u][0].tag));
			assign el1 = rs_v_reg[u][1] && op_rdy_i[u][1] && (!exec_ser(rs_reg[u][1].cls) ||
				(old_v_reg && oldest_v_i && old_tag_reg == rs_reg[u][1].tag &&
				oldest_tag_i == rs_reg[u][1].tag));
			if (u >= `ESX_U_SI0 && u <= `ESX_U_MC) begin : g_ooo
				assign go[u]  = (el0 || el1) && unit_free[u];
				assign sel[u] = !el0;
			end else begin : g_ino
				assign go[u]  = el0 && unit_free[u];
				assign sel[u] = 1'b0;
			end
			// dispatch refused while both entries hold or a string owns the buffer
			assign disp_rdy_o[u] = rs_v_reg[u] != `ESX_RS_FULL && str_reg == STR_IDLE;
			assign dacc = disp_i.valid && disp_i.unit == 3'(u) && disp_rdy_o[u] && !flush_now;

			// remove the issued entry, then place the dispatched one
			always_comb begin
				e0_next = rs_reg[u][0];
				e1_next = rs_reg[u][1];
				v_next  = rs_v_reg[u];
				if (go[u] && !sel[u]) begin
					e0_next = rs_reg[u][1];
					v_next  = {1'b0, rs_v_reg[u][1]};
				end else if (go[u]) begin
					v_next[1] = 1'b0;
				end
				if (dacc && !v_next[0]) begin
					e0_next   = disp_i;
					v_next[0] = 1'b1;
				end else if (dacc) begin
					e1_next   = disp_i;
					v_next[1] = 1'b1;
				end
			end

			// adder, logic and shifter are the three simple subunits
			assign sub = rs_reg[u][sel[u]].cls == CLS_LOGIC ? 3'b010 :
				rs_reg[u][sel[u]].cls == CLS_SHIFT ? 3'b100 : 3'b001;

			always_ff @(posedge mclk) begin
				rs_reg[u][0] <= e0_next;
				rs_reg[u][1] <= e1_next;
				rs_v_reg[u]  <= (rst || flush_now) ? 2'b00 : v_next;
			end

			// issue record for the unit datapath
			always_ff @(posedge mclk) begin
				iss_reg[u].valid     <= !rst && go[u] && !flush_now;
				iss_reg[u].tag       <= rs_reg[u][sel[u]].tag;
				iss_reg[u].cls       <= rs_reg[u][sel[u]].cls;
				iss_reg[u].sub       <= sub;
				iss_reg[u].same_cmpl <= !(rs_reg[u][sel[u]].oe ||
					rs_reg[u][sel[u]].cls == CLS_MTCTLR);
			end
			assign iss_o[u] = iss_reg[u];

			a_rs_cap: assert property (@(posedge mclk) disable iff (rst)
				!rs_v_reg[u][0] |-> !rs_v_reg[u][1])
				else $error("station holds entry 1 without entry 0");
			a_ser_wait: assert property (@(posedge mclk) disable iff (rst)
				go[u] && exec_ser(rs_reg[u][sel[u]].cls) |->
				$past(oldest_tag_i) == rs_reg[u][sel[u]].tag)
				else $error("serialized op issued before being oldest");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// branch unit: resolved-uncompleted count and prediction check
	logic [1:0]    br_cnt_reg;
	esx_redir_type redir_reg;
	logic          br_go;

	assign br_go = go[`ESX_U_BR] && rs_reg[`ESX_U_BR][0].cls == CLS_BRANCH;
	assign unit_free[`ESX_U_BR] = br_cnt_reg < `ESX_BR_MAX;
	assign unit_free[`ESX_U_SI0] = 1'b1;
	assign unit_free[`ESX_U_SI1] = 1'b1;

	always_ff @(posedge mclk) begin
		if (rst || flush_now)
			br_cnt_reg <= 2'd0;
		else
			br_cnt_reg <= br_cnt_reg + 2'(br_go) -
				2'(cmpl_i.valid && cmpl_i.cls == CLS_BRANCH && br_cnt_reg != 2'd0);
	end

	// compare direction and target; redirect to the actual address
	always_ff @(posedge mclk) begin
		redir_reg.valid <= !rst && !flush_now && br_go &&
			(br_res_i.pred_taken != br_res_i.taken ||
			br_res_i.pred_target != br_res_i.target);
		redir_reg.addr  <= br_res_i.target;
	end
	assign redir_o = redir_reg;

	a_br_limit: assert property (@(posedge mclk) disable iff (rst)
		br_cnt_reg == `ESX_BR_MAX |-> !br_go)
		else $error("third resolved branch accepted");

	////////////////////////////////////////////////////////////////////////
	// multicycle integer unit: multiply early exit, divide, spr moves
	logic [5:0]  mc_cnt_reg;
	esx_iss_type mc_op_reg;
	esx_iss_type mc_done_reg;
	esx_cls_type mc_cls;

	assign mc_cls = rs_reg[`ESX_U_MC][sel[`ESX_U_MC]].cls;
	assign unit_free[`ESX_U_MC] = mc_cnt_reg == 6'd0;

	always_ff @(posedge mclk) begin
		if (rst || flush_now)
			mc_cnt_reg <= 6'd0;
		else if (go[`ESX_U_MC])
			mc_cnt_reg <= mc_cls == CLS_DIV ? `ESX_DIV_CYC :
				mc_cls != CLS_MUL ? `ESX_SPR_CYC :
				rs_reg[`ESX_U_MC][sel[`ESX_U_MC]].short_op ?
				`ESX_MUL_SHORT : `ESX_MUL_LONG;
		else if (mc_cnt_reg != 6'd0)
			mc_cnt_reg <= mc_cnt_reg - 6'd1;
	end

	// done carries whether completion may share the finish cycle
	always_ff @(posedge mclk) begin
		// captured at issue so a one-cycle move still reports its own tag
		if (go[`ESX_U_MC]) begin
			mc_op_reg.tag       <= rs_reg[`ESX_U_MC][sel[`ESX_U_MC]].tag;
			mc_op_reg.cls       <= mc_cls;
			mc_op_reg.sub       <= 3'b001;
			mc_op_reg.same_cmpl <= !(rs_reg[`ESX_U_MC][sel[`ESX_U_MC]].oe ||
				mc_cls == CLS_MTCTLR);
		end
		mc_op_reg.valid   <= 1'b0;
		mc_done_reg       <= mc_op_reg;
		mc_done_reg.valid <= !rst && !flush_now && mc_cnt_reg == 6'd1;
	end
	assign mc_done_o = mc_done_reg;

	////////////////////////////////////////////////////////////////////////
	// float unit: two pipe stages plus done register, blocking ops
	esx_iss_type fp_p_reg [2];
	esx_iss_type fp_blk_op_reg;
	esx_iss_type fp_done_reg;
	logic [5:0]  fp_blk_reg;
	logic        fp_cr_reg;
	esx_cls_type fp_cls;
	logic        fp_blocks;

	assign fp_cls    = rs_reg[`ESX_U_FP][0].cls;
	assign fp_blocks = fp_cls inside {CLS_FDIV, CLS_FDIVS, CLS_FRES, CLS_FSTAT, CLS_MCRFS};
	assign unit_free[`ESX_U_FP] = fp_blk_reg == 6'd0;

	// long ops hold the pipe; the count sets their own latency
	always_ff @(posedge mclk) begin
		if (rst || flush_now)
			fp_blk_reg <= 6'd0;
		else if (go[`ESX_U_FP] && fp_blocks)
			fp_blk_reg <= fp_cls == CLS_FDIV ? `ESX_FDIV_CYC - 6'd1 :
				fp_cls == CLS_FDIVS ? `ESX_FDIVS_CYC - 6'd1 :
				fp_cls == CLS_FRES ? `ESX_FRES_CYC - 6'd1 : `ESX_FP_BLK_STAT;
		else if (fp_blk_reg != 6'd0)
			fp_blk_reg <= fp_blk_reg - 6'd1;
	end

	always_ff @(posedge mclk) begin
		if (go[`ESX_U_FP]) begin
			fp_blk_op_reg.tag <= rs_reg[`ESX_U_FP][0].tag;
			fp_blk_op_reg.cls <= fp_cls;
		end
		fp_blk_op_reg.valid     <= 1'b0;
		fp_blk_op_reg.sub       <= 3'b000;
		fp_blk_op_reg.same_cmpl <= 1'b0;
	end

	// three-cycle pipe, one issue per cycle, at most three in flight
	always_ff @(posedge mclk) begin
		fp_p_reg[0].valid <= !rst && !flush_now && go[`ESX_U_FP] && !fp_blocks;
		fp_p_reg[0].tag   <= rs_reg[`ESX_U_FP][0].tag;
		fp_p_reg[0].cls   <= fp_cls;
		fp_p_reg[0].sub   <= 3'b000;
		fp_p_reg[0].same_cmpl <= 1'b1;
		fp_p_reg[1]       <= fp_p_reg[0];
		fp_p_reg[1].valid <= !rst && !flush_now && fp_p_reg[0].valid;
	end

	// result goes to rename buffers and stations; cr result to branch
	always_ff @(posedge mclk) begin
		fp_done_reg <= fp_p_reg[1].valid ? fp_p_reg[1] : fp_blk_op_reg;
		fp_done_reg.valid <= !rst && !flush_now &&
			(fp_p_reg[1].valid || fp_blk_reg == 6'd1);
		fp_cr_reg <= !rst && !flush_now && (fp_p_reg[1].valid ||
			(fp_blk_reg == 6'd1 && fp_blk_op_reg.cls != CLS_MCRFS));
	end
	assign fp_done_o   = fp_done_reg;
	assign fp_cr_fwd_o = fp_cr_reg;

	a_fp_lat: assert property (@(posedge mclk) disable iff (rst || flush_now)
		go[`ESX_U_FP] && !fp_blocks ##1 !flush_now [*2] |=> fp_done_reg.valid)
		else $error("float result not three cycles after issue");
	a_fp_block: assert property (@(posedge mclk) disable iff (rst)
		go[`ESX_U_FP] && fp_cls == CLS_FDIV |=> !go[`ESX_U_FP] [*8])
		else $error("float issue during divide");
	a_fp_crfwd: assert property (@(posedge mclk) disable iff (rst)
		fp_done_reg.valid && fp_done_reg.cls == CLS_MCRFS |-> !fp_cr_reg)
		else $error("status move forwarded its cr result early");

	////////////////////////////////////////////////////////////////////////
	// load/store unit: address stage, cache stage, store queue
	esx_disp_type ls1_reg;
	esx_disp_type ls2_reg;
	esx_disp_type ls_head;
	logic [11:0]  sq_ea_reg [`ESX_SQ_DEPTH];
	logic [3:0]   sq_v_reg;
	logic [3:0]   sq_wr_reg;
	logic [2:0]   sq_tail_reg;
	logic [2:0]   sq_fin_reg;
	logic [2:0]   sq_cmp_reg;
	logic [2:0]   sq_head_reg;
	logic         alias_hit;
	logic         pipe_store;
	logic [2:0]   sq_used;

	assign ls_head    = rs_reg[`ESX_U_LS][0];
	assign pipe_store = (ls1_reg.valid && ls1_reg.cls == CLS_STORE) ||
		(ls2_reg.valid && ls2_reg.cls == CLS_STORE);
	assign sq_used    = sq_tail_reg - sq_head_reg;

	// a load whose low address bits meet an unwritten older store waits
	always_comb begin
		alias_hit = pipe_store && ((ls1_reg.cls == CLS_STORE && ls1_reg.valid &&
			ls1_reg.ea_lo == ls_head.ea_lo) || (ls2_reg.cls == CLS_STORE &&
			ls2_reg.valid && ls2_reg.ea_lo == ls_head.ea_lo));
		for (int i = 0; i < `ESX_SQ_DEPTH; i++)
			if (sq_v_reg[i] && !sq_wr_reg[i] && sq_ea_reg[i] == ls_head.ea_lo)
				alias_hit = 1'b1;
	end

	// barrier waits for every older access so uncached loads stay in order
	assign unit_free[`ESX_U_LS] =
		!(ls_head.cls == CLS_LOAD && alias_hit) &&
		!(ls_head.cls == CLS_BARRIER && (sq_used != 3'd0 || ls1_reg.valid ||
		ls2_reg.valid)) &&
		!(ls_head.cls == CLS_STORE && sq_used + 3'(pipe_store) >= 3'(`ESX_SQ_DEPTH) - 3'd1);

	always_ff @(posedge mclk) begin
		ls1_reg       <= ls_head;
		ls1_reg.valid <= !rst && !flush_now && go[`ESX_U_LS];
		ls2_reg       <= ls1_reg;
		ls2_reg.valid <= !rst && !flush_now && ls1_reg.valid;
	end
	assign ls_done_o = ls2_reg;

	assign dc_wr_req_o = sq_cmp_reg != sq_fin_reg;
	assign dc_wr_idx_o = sq_cmp_reg[1:0];
	assign dc_wr_ea_o  = sq_ea_reg[sq_cmp_reg[1:0]];

	// queue pointers walk finished, completed and committed regions
	always_ff @(posedge mclk) begin
		if (rst) begin
			sq_tail_reg <= 3'd0;
			sq_fin_reg  <= 3'd0;
			sq_cmp_reg  <= 3'd0;
			sq_head_reg <= 3'd0;
			sq_v_reg    <= 4'h0;
			sq_wr_reg   <= 4'h0;
		end else begin
			if (flush_now) begin
				sq_tail_reg <= sq_fin_reg;
				for (int i = 0; i < `ESX_SQ_DEPTH; i++)
					if (3'(i - sq_fin_reg) % 3'(`ESX_SQ_DEPTH) < sq_tail_reg - sq_fin_reg)
						sq_v_reg[i] <= 1'b0;
			end else if (ls2_reg.valid && ls2_reg.cls == CLS_STORE) begin
				sq_ea_reg[sq_tail_reg[1:0]] <= ls2_reg.ea_lo;
				sq_v_reg[sq_tail_reg[1:0]]  <= 1'b1;
				sq_wr_reg[sq_tail_reg[1:0]] <= 1'b0;
				sq_tail_reg <= sq_tail_reg + 3'd1;
			end
			if (cmpl_i.valid && cmpl_i.cls == CLS_STORE && sq_fin_reg != sq_tail_reg)
				sq_fin_reg <= sq_fin_reg + 3'd1;
			if (dc_wr_req_o && (dc_hit_i || dc_miss_i))
				sq_cmp_reg <= sq_cmp_reg + 3'd1;
			if (dc_wr_req_o && dc_hit_i)
				sq_wr_reg[sq_cmp_reg[1:0]] <= 1'b1;
			if (dc_fill_i)
				sq_wr_reg[dc_fill_idx_i] <= 1'b1;
			if (sq_head_reg != sq_cmp_reg && sq_wr_reg[sq_head_reg[1:0]]) begin
				sq_head_reg <= sq_head_reg + 3'd1;
				sq_v_reg[sq_head_reg[1:0]] <= 1'b0;
			end
		end
	end

	a_ls_lat: assert property (@(posedge mclk) disable iff (rst || flush_now)
		go[`ESX_U_LS] ##1 !flush_now |=> ls2_reg.valid)
		else $error("load/store not done two cycles after issue");
	a_alias_hold: assert property (@(posedge mclk) disable iff (rst)
		go[`ESX_U_LS] && ls_head.cls == CLS_LOAD |-> !alias_hit)
		else $error("load passed an aliasing store");
	a_flush_clear: assert property (@(posedge mclk) disable iff (rst)
		flush_now |=> rs_v_reg[`ESX_U_LS] == 2'b00 && !ls1_reg.valid && flush_reg)
		else $error("flush left younger work behind");

	////////////////////////////////////////////////////////////////////////
	// string/multiple sequencer: one word op per cycle after the first
	logic [4:0] str_left_reg;

	always_ff @(posedge mclk) begin
		if (rst || flush_now) begin
			str_reg      <= STR_IDLE;
			str_left_reg <= 5'd0;
		end else begin
			unique case (str_reg)
				STR_IDLE: if (disp_i.valid && disp_i.cls == CLS_STRING &&
					disp_i.unit == 3'(`ESX_U_LS) && disp_rdy_o[`ESX_U_LS]) begin
					str_reg      <= disp_i.words > 5'd1 ? STR_RUN : STR_LAST;
					str_left_reg <= disp_i.words - 5'd1;
				end
				STR_RUN: begin
					str_left_reg <= str_left_reg - 5'd1;
					if (str_left_reg == 5'd1)
						str_reg <= STR_IDLE;
				end
				STR_LAST: str_reg <= STR_IDLE;
			endcase
		end
	end
	assign str_hold_o = str_reg != STR_IDLE;
	assign str_word_o = str_reg == STR_RUN;

	a_str_hold: assert property (@(posedge mclk) disable iff (rst || flush_now)
		$rose(str_hold_o) |-> disp_rdy_o == 6'h00 && $past(disp_i.cls == CLS_STRING))
		else $error("string left the dispatch buffer too soon");
endmodule

// [hdl/esx_pkg.sv]
// types shared by the execution control block and its surroundings
// assumes esx_consts.svh is on the include path
package esx_pkg;
`include "esx_consts.svh"

	typedef enum logic [4:0] {
		CLS_ADD, CLS_LOGIC, CLS_SHIFT, CLS_CRLOG, CLS_MFSPR, CLS_MTSPR,
		CLS_MTCTLR, CLS_MTXER, CLS_MCRXR, CLS_CARRY, CLS_MUL, CLS_DIV,
		CLS_BRANCH, CLS_ISYNC, CLS_FARITH, CLS_FDIV, CLS_FDIVS, CLS_FRES,
		CLS_FSTAT, CLS_MCRFS, CLS_LOAD, CLS_STORE, CLS_STRING, CLS_BARRIER
	} esx_cls_type;

	typedef struct packed {
		logic        valid;
		logic [2:0]  unit;
		esx_cls_type cls;
		logic [3:0]  tag;
		logic [11:0] ea_lo;
		logic        uncached;
		logic        short_op;
		logic        oe;
		logic [4:0]  words;
	} esx_disp_type;

	typedef struct packed {
		logic        valid;
		logic [3:0]  tag;
		esx_cls_type cls;
		logic        sets_so;
		logic        trap_ve;
		logic        trap_ze;
		logic        record;
		logic        str_zero;
	} esx_cmpl_type;

	typedef struct packed {
		logic        pred_taken;
		logic [31:0] pred_target;
		logic        taken;
		logic [31:0] target;
	} esx_br_type;

	typedef struct packed {
		logic        valid;
		logic [3:0]  tag;
		esx_cls_type cls;
		logic [2:0]  sub;
		logic        same_cmpl;
	} esx_iss_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} esx_redir_type;

	typedef enum logic [2:0] {
		STR_IDLE = 3'b001,
		STR_RUN  = 3'b010,
		STR_LAST = 3'b100
	} esx_str_type;
endpackage
